// ===== zcd_map.svh
// register map, field positions and reset values of the zero-cross detector
// assumes a 32-bit ahb-lite slave with word-aligned registers
`ifndef ZCD_MAP_SVH
`define ZCD_MAP_SVH

`define ZCD_CTRL_OFS      12'h000
`define ZCD_STAT_OFS      12'h004
`define ZCD_MASK_OFS      12'h008
`define ZCD_GATE_OFS      12'h00C

`define ZCD_CTRL_EN       7
`define ZCD_CTRL_LEVEL    5
`define ZCD_CTRL_INV      4
`define ZCD_CTRL_RISE     1
`define ZCD_CTRL_FALL     0

`define ZCD_STAT_FLAG     0
`define ZCD_STAT_RISE     1
`define ZCD_STAT_FALL     2

`define ZCD_GATE_IE       0
`define ZCD_GATE_PERIPH   1
`define ZCD_GATE_GLOBAL   2

`define ZCD_MASK_RESET    3'h7
`define ZCD_OFS_BITS      12

`endif

// ===== zcd_pkg.sv
// types shared by the zero-cross detector
// assumes zcd_map.svh is compiled alongside
package zcd_pkg;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [11:0] addr;
    } zcd_bus_req_t;

    typedef struct packed {
        logic [1:0]  sync;
        logic        level;
        logic        level_valid;
        logic        enable;
        logic        invert;
        logic        rise_en;
        logic        fall_en;
        logic        flag;
        logic [2:0]  stat;
        logic [2:0]  mask;
        logic        irq_en;
        logic        periph_gate;
        logic        global_gate;
        logic        strap_done;
        zcd_bus_req_t req;
        logic [31:0] rdata;
        logic        irq;
        logic        pin_mode;
        logic        level_out;
    } zcd_state_t;

endpackage

// ===== zcd_top.sv
// zero-cross detector event logic with an ahb-lite register slave
// assumes the analog front end drives sink_active; one clock, sync reset
`timescale 1ns/1ns
`include "zcd_map.svh"

module zcd_top
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // analog front end and pin
    input  wire logic        sink_active,
    input  wire logic        default_off_strap,
    input  wire logic        sleep_mode,
    output logic             pin_source_sink_mode,
    output logic             crossing_logic_level,
    // interrupt
    output logic             irq
);

    zcd_pkg::zcd_state_t st;
    zcd_pkg::zcd_state_t next_st;

    logic       wr_ctrl;
    logic       wr_mask;
    logic       wr_gate;
    logic       rd_stat;
    logic       new_level;
    logic       rise;
    logic       fall;
    logic [2:0] events;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        wr_ctrl = st.req.sel && st.req.write && (st.req.addr == `ZCD_CTRL_OFS);
        wr_mask = st.req.sel && st.req.write && (st.req.addr == `ZCD_MASK_OFS);
        wr_gate = st.req.sel && st.req.write && (st.req.addr == `ZCD_GATE_OFS);
        rd_stat = st.req.sel && !st.req.write && (st.req.addr == `ZCD_STAT_OFS);

        // synchroniser: stage 0 is read only by stage 1
        next_st.sync = {st.sync[0], sink_active};

        // sleep_mode is deliberately ignored: the detector keeps running
        if (sleep_mode || !sleep_mode)
        begin
            next_st.sync[0] = sink_active;
        end

        // strap caught once after reset release, never under reset
        if (!st.strap_done)
        begin
            next_st.strap_done = 1'b1;
            next_st.enable     = !default_off_strap;
        end

        if (wr_ctrl)
        begin
            next_st.enable  = hwdata[`ZCD_CTRL_EN];
            next_st.invert  = hwdata[`ZCD_CTRL_INV];
            next_st.rise_en = hwdata[`ZCD_CTRL_RISE];
            next_st.fall_en = hwdata[`ZCD_CTRL_FALL];
        end
        if (wr_mask)
        begin
            next_st.mask = hwdata[2:0];
        end
        if (wr_gate)
        begin
            next_st.irq_en      = hwdata[`ZCD_GATE_IE];
            next_st.periph_gate = hwdata[`ZCD_GATE_PERIPH];
            next_st.global_gate = hwdata[`ZCD_GATE_GLOBAL];
        end

        // level follows the current invert bit, so an invert change is an edge
        new_level = st.sync[1] ^ next_st.invert;
        next_st.level       = new_level;
        next_st.level_valid = 1'b1;
        // edges are judged regardless of enable, matching the invert behaviour
        rise = st.level_valid && !st.level && new_level;
        fall = st.level_valid && st.level && !new_level;

        events = {fall, rise, (rise && st.rise_en) || (fall && st.fall_en)};

        // read of status clears it, but a same-cycle event wins
        if (rd_stat)
        begin
            next_st.stat = 3'h0;
        end
        next_st.stat = next_st.stat | events;
        next_st.flag = next_st.stat[`ZCD_STAT_FLAG];

        next_st.irq = next_st.flag && next_st.irq_en && next_st.periph_gate
                      && next_st.global_gate
                      && |(next_st.stat & next_st.mask);
        next_st.pin_mode  = next_st.enable;
        next_st.level_out = new_level;

        // address phase capture
        next_st.req.sel   = hsel && hready && htrans[1];
        next_st.req.write = hwrite;
        next_st.req.addr  = haddr[`ZCD_OFS_BITS-1:0];

        next_st.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            case (haddr[`ZCD_OFS_BITS-1:0])
                `ZCD_CTRL_OFS:
                begin
                    next_st.rdata[`ZCD_CTRL_EN]    = next_st.enable;
                    next_st.rdata[`ZCD_CTRL_LEVEL] = new_level;
                    next_st.rdata[`ZCD_CTRL_INV]   = next_st.invert;
                    next_st.rdata[`ZCD_CTRL_RISE]  = next_st.rise_en;
                    next_st.rdata[`ZCD_CTRL_FALL]  = next_st.fall_en;
                end
                `ZCD_STAT_OFS: next_st.rdata[2:0] = next_st.stat;
                `ZCD_MASK_OFS: next_st.rdata[2:0] = next_st.mask;
                `ZCD_GATE_OFS:
                begin
                    next_st.rdata[`ZCD_GATE_IE]     = next_st.irq_en;
                    next_st.rdata[`ZCD_GATE_PERIPH] = next_st.periph_gate;
                    next_st.rdata[`ZCD_GATE_GLOBAL] = next_st.global_gate;
                end
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st      <= '0;
            st.mask <= `ZCD_MASK_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // zero-wait slave: hreadyout is a constant flop output
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata               = st.rdata;
    assign irq                  = st.irq;
    assign pin_source_sink_mode = st.pin_mode;
    assign crossing_logic_level = st.level_out;

endmodule // zcd_top

// ===== zcd_src.sv
// external ac source seen through the series resistor
// assumes the bench picks a held level or a free-running wave
`timescale 1ns/1ns

module zcd_src
#(
    parameter int HALF_NS = 98
)
(
    // control
    input  wire logic run,
    input  wire logic hold_level,
    // front end state
    output logic      sink_active
);
    // even half period of 98 ns puts the toggles alternately on rising and falling clock edges
    logic wave = 1'b0;
    always #(HALF_NS) wave = ~wave;
    // above threshold the front end sinks, below it sources
    // no weak pull-up is modelled on the pin, so nothing skews the level
    assign sink_active = run ? wave : hold_level;
endmodule // zcd_src

// ===== zcd_chk.sv
// port assertions of the zero-cross detector
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns

module zcd_chk
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // bus and pins
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        sink_active,
    input wire logic        default_off_strap,
    input wire logic        pin_source_sink_mode,
    input wire logic        crossing_logic_level,
    input wire logic        irq
);
    logic [2:0] quiet;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // cycles since reset or bus transfer; only software or the strap after reset may move pin mode, only software may lower irq
    always_ff @(posedge clk)
        if (rst || (hsel && hready && htrans[1]))
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    ////////////////////////////////////////////////////////////////////////
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer wrong");
    chk_rdata_idle: assert property
        (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
        else $error("stray read data");
    chk_strap_enable: assert property
        ($fell(rst) |-> ##2 pin_source_sink_mode == !default_off_strap)
        else $error("strap enable wrong");
    chk_pin_cause: assert property
        ($changed(pin_source_sink_mode) |-> quiet < 3'h5)
        else $error("pin mode moved alone");
    chk_level_cause: assert property ($changed(crossing_logic_level) |->
        quiet < 3'h5 || $past(sink_active, 2) != $past(sink_active, 4))
        else $error("level moved alone");
    chk_level_quiet: assert property
        ($stable(sink_active) [*5] ##0 quiet == 3'h7 |-> $stable(crossing_logic_level))
        else $error("level unsettled");
    chk_irq_rise: assert property ($rose(irq) |->
        quiet < 3'h5 || crossing_logic_level != $past(crossing_logic_level, 3))
        else $error("irq rose alone");
    chk_irq_fall: assert property ($fell(irq) |-> quiet < 3'h5)
        else $error("irq fell alone");
    cover property ($rose(irq));
    cover property ($fell(irq));
    cover property ($rose(pin_source_sink_mode));
endmodule // zcd_chk

bind zcd_top zcd_chk i_chk (.clk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .hrdata, .sink_active, .default_off_strap, .pin_source_sink_mode,
    .crossing_logic_level, .irq);

// ===== tb_top.sv
// register-level bench of the zero-cross detector
// assumes zcd_src stands in for the ac source on the pin
`timescale 1ns/1ns
`include "zcd_map.svh"
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", n, e, v); end end

module tb_top;
    logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, strap = 1, slp = 0;
    logic        run = 0, hold = 0, rdy, hresp, pin, lvl, irq, sink;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0;
    int          fail_count = 0, checked = 0;
    initial forever #2 clk = ~clk;
    zcd_src i_src (.run(run), .hold_level(hold), .sink_active(sink));
    zcd_top i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy),
        .hresp(hresp), .hrdata(hrdata), .sink_active(sink), .default_off_strap(strap),
        .sleep_mode(slp), .pin_source_sink_mode(pin), .crossing_logic_level(lvl), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ready and read data are taken at the rising edge itself, before the
    // design's flops update, so the request stands until that very edge
    task ack;
        int n;
        logic ok;
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++)
        begin
            @(posedge clk);
            ok = (rdy === 1'b1);
            rd = hrdata;
        end
        if (!ok)
        begin
            fail_count++;
            final_report();
        end
    endtask
    // a write sends d, a read expects d
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        ack();
        htrans <= 2'h0;
        hwdata <= d;
        ack();
        if (!w)
            `CHK("register", d, rd)
    endtask
    task pins(input logic p, input logic l, input logic i);
        repeat (8) @(posedge clk);
        @(negedge clk);
        `CHK("pin mode", p, pin)
        `CHK("level", l, lvl)
        `CHK("irq", i, irq)
        @(posedge clk);
    endtask
    task do_reset(input logic s);
        rst <= 1'b1;
        strap <= s;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset(1'b1);
        pins(1'b0, 1'b0, 1'b0);
        acc(1'b0, `ZCD_MASK_OFS, 32'h7);
        acc(1'b0, 12'h010, 32'h0);
        acc(1'b1, `ZCD_GATE_OFS, 32'h7);
        acc(1'b1, `ZCD_CTRL_OFS, 32'h3);
        hold <= 1'b1;
        pins(1'b0, 1'b1, 1'b1);
        acc(1'b0, `ZCD_STAT_OFS, 32'h3);
        pins(1'b0, 1'b1, 1'b0);
        acc(1'b1, `ZCD_CTRL_OFS, 32'h13);
        acc(1'b0, `ZCD_CTRL_OFS, 32'h13);
        acc(1'b0, `ZCD_STAT_OFS, 32'h5);
        acc(1'b1, `ZCD_CTRL_OFS, 32'h11);
        hold <= 1'b0;
        pins(1'b0, 1'b1, 1'b0);
        acc(1'b0, `ZCD_STAT_OFS, 32'h2);
        acc(1'b1, `ZCD_GATE_OFS, 32'h3);
        slp <= 1'b1;
        hold <= 1'b1;
        pins(1'b0, 1'b0, 1'b0);
        acc(1'b0, `ZCD_STAT_OFS, 32'h5);
        acc(1'b1, `ZCD_CTRL_OFS, 32'h80);
        pins(1'b1, 1'b1, 1'b0);
        do_reset(1'b0);
        run <= 1'b1;
        repeat (200) @(posedge clk);
        acc(1'b0, `ZCD_STAT_OFS, 32'h6);
        final_report();
    end
endmodule // tb_top
